// ---- common/pmc_map.svh ----
// register map, field positions, reset values and timing figures of the power mode controller
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PMC_OFF_MODE      8'h00
`define PMC_OFF_ACT_TMPL  8'h04
`define PMC_OFF_ALT_TMPL  8'h08
`define PMC_OFF_WAKE_EN   8'h0C
`define PMC_OFF_BOOST     8'h10
`define PMC_OFF_TW_CTRL   8'h14
`define PMC_OFF_STATUS    8'h18

// ---------------------------------------------------------------
// field positions and widths
// ---------------------------------------------------------------
`define PMC_RES_W         8
`define PMC_RES_CPU       0
`define PMC_RES_RTC       7
`define PMC_IRQ_W         4
`define PMC_IRQ_PIN       3
`define PMC_RST_W         3
`define PMC_WEN_TW        4
`define PMC_WEN_RST_LO    5
`define PMC_TW_W          13
`define PMC_TW_CLR        0
`define PMC_ST_MODE_LO    0
`define PMC_ST_SEQ_LO     2
`define PMC_ST_TW_LO      16
`define PMC_FREQ_32K      2'h3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PMC_RST_TMPL      8'hFF
`define PMC_RST_ALT_TMPL  8'hFE
`define PMC_RST_WAKE_EN   8'hFF
`define PMC_RST_TW        13'h0000

// ---------------------------------------------------------------
// timing: clock period and wake limits in ns, sequencer margin in cycles
// ---------------------------------------------------------------
`define PMC_CLK_NS        5
`define PMC_SLEEP_WAKE_NS 15000
`define PMC_HIB_WAKE_NS   100000
`define PMC_WAKE_MARGIN   8

`endif

// ---- common/pmc_pkg.sv ----
// types shared by the power mode controller
package pmc_pkg;

	// global chip power modes
	typedef enum logic [1:0] {
		PMC_ACTIVE = 2'h0,
		PMC_ALT    = 2'h1,
		PMC_SLEEP  = 2'h2,
		PMC_HIB    = 2'h3
	} pmc_mode_t;

	// power sequencer, gray coded from run through ungate; the ungate to run step flips all three bits
	typedef enum logic [2:0] {
		PMC_S_RUN    = 3'h0,
		PMC_S_GATE   = 3'h1,
		PMC_S_REGOFF = 3'h3,
		PMC_S_LOW    = 3'h2,
		PMC_S_REGON  = 3'h6,
		PMC_S_UNGATE = 3'h7
	} pmc_state_t;

	// boost converter digital controls
	typedef struct packed {
		logic       auto_pulse;
		logic [1:0] freq;
		logic       active;
		logic       en;
	} pmc_boost_t;

endpackage

// ---- design/pmc_power_ctrl.sv ----
// global power mode sequencer, wake routing and boost mode control with apb registers
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"

// Summary of operation
// - active mode follows active template bits
// - disabled resource: clocks gated, bias off
// - processor self-off, re-enabled at next wake
// - wake forces active mode, processor on
// - reset selects active mode
// - alternate active uses its own template
// - sleep wake resumes within 15 us
// - settle delay lets regulators stabilise first
// - hibernate keeps configuration and memory state
// - hibernate holds pin outputs and settings
// - only pin interrupt wakes from hibernate
// - hibernate wake resumes under 100 us
// - each wake source enabled individually
// - interrupt sources include timewheel, pins, supervisor
// - reset sources: reset pin, watchdog, precise
// - boost active or standby mode
// - auto pulse on both crystal edges when low
// - four boost switching frequency choices
// - slowest setting uses watch crystal clock
// - boost mode free in active and sleep
// - boost forced active during hibernate; forced only while the sequencer is in its low state
// - sleep keeps only timewheel and rtc
// - 13-bit 1 kHz timewheel, firmware resettable
module pmc_power_ctrl #(
	parameter int HIB_WAKE_CYC = `PMC_HIB_WAKE_NS / `PMC_CLK_NS
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [`PMC_IRQ_W-1:0] wake_irq,
	input  wire logic [`PMC_RST_W-1:0] wake_rst,
	input  wire logic                  lso_tick_1k,
	input  wire logic                  xtal_32k,
	input  wire logic                  boost_below,
	input  wire logic [2:0]            boost_osc,
	output logic      [`PMC_RES_W-1:0] res_clk_en,
	output logic      [`PMC_RES_W-1:0] res_bias_en,
	output logic                       bus_clk_en,
	output logic                       reg_en,
	output logic                       pin_hold,
	output logic                       boost_en,
	output logic                       boost_active,
	output logic                       boost_sw_clk,
	output logic                       boost_pulse
);

	// ---------------------------------------------------------------
	// timing counts
	// ---------------------------------------------------------------
	// wake limits are maxima, so round down and leave sequencer margin
	localparam int SLEEP_CYC = `PMC_SLEEP_WAKE_NS / `PMC_CLK_NS;
	localparam int SLEEP_SETTLE = SLEEP_CYC - `PMC_WAKE_MARGIN;
	localparam int HIB_SETTLE = HIB_WAKE_CYC - `PMC_WAKE_MARGIN;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	pmc_pkg::pmc_mode_t  mode_q;
	pmc_pkg::pmc_state_t st_q;
	pmc_pkg::pmc_state_t st_d;
	pmc_pkg::pmc_boost_t boost_q;
	logic [`PMC_RES_W-1:0] act_tmpl_q;
	logic [`PMC_RES_W-1:0] alt_tmpl_q;
	logic [7:0]            wake_en_q;
	logic [`PMC_TW_W-1:0]  tw_q;
	logic                  wake_pend_q;
	logic [15:0]           settle_q;
	logic                  xtal_q;
	logic [15:0]           lat_q;

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	wire acc     = psel & penable & pready;
	wire wr      = acc & pwrite;
	wire setup   = psel & ~penable;
	wire hit_md  = paddr == `PMC_OFF_MODE;
	wire hit_act = paddr == `PMC_OFF_ACT_TMPL;
	wire hit_alt = paddr == `PMC_OFF_ALT_TMPL;
	wire hit_wen = paddr == `PMC_OFF_WAKE_EN;
	wire hit_bst = paddr == `PMC_OFF_BOOST;
	wire hit_tw  = paddr == `PMC_OFF_TW_CTRL;
	wire hit_st  = paddr == `PMC_OFF_STATUS;
	wire hit_any = hit_md | hit_act | hit_alt | hit_wen | hit_bst | hit_tw | hit_st;

	// status word shows live mode, sequencer and timewheel
	wire [31:0] status_w = (32'({tw_q}) << `PMC_ST_TW_LO)
		| (32'({st_q}) << `PMC_ST_SEQ_LO)
		| (32'({mode_q}) << `PMC_ST_MODE_LO);
	wire [31:0] rd_data = hit_md  ? 32'({mode_q})
		: hit_act ? 32'({act_tmpl_q})
		: hit_alt ? 32'({alt_tmpl_q})
		: hit_wen ? 32'({wake_en_q})
		: hit_bst ? 32'({boost_q})
		: hit_st  ? status_w
		: 32'h00000000;

	// apb slave: one wait-free access phase, unmapped gives slverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			prdata  <= setup && !pwrite ? rd_data : 32'h00000000;
			pslverr <= setup & ~hit_any;
		end
	end

	// ---------------------------------------------------------------
	// wake source qualification
	// ---------------------------------------------------------------
	wire in_hib   = mode_q == pmc_pkg::PMC_HIB;
	wire tw_ev    = lso_tick_1k & (&tw_q) & ~in_hib;
	wire [7:0] src_w = {wake_rst, tw_ev, wake_irq};
	wire [7:0] src_en = src_w & wake_en_q;
	wire pin_ev   = src_en[`PMC_IRQ_PIN];
	wire wake_ev  = in_hib ? pin_ev : |src_en;
	wire low_req  = mode_q == pmc_pkg::PMC_SLEEP || in_hib;
	wire md_wr    = wr & hit_md;

	// ---------------------------------------------------------------
	// sequencer next state
	// ---------------------------------------------------------------
	// a wake that lands mid entry is held pending and finishes the cycle
	always_comb begin
		st_d = st_q;
		case (st_q)
			pmc_pkg::PMC_S_RUN: begin
				// a wake in the cycle after the mode write puts mode back to active, so stay put
				if (low_req && !wake_ev) begin
					st_d = pmc_pkg::PMC_S_GATE;
				end
			end
			pmc_pkg::PMC_S_GATE: begin
				st_d = pmc_pkg::PMC_S_REGOFF;
			end
			pmc_pkg::PMC_S_REGOFF: begin
				st_d = pmc_pkg::PMC_S_LOW;
			end
			pmc_pkg::PMC_S_LOW: begin
				if (wake_pend_q) begin
					st_d = pmc_pkg::PMC_S_REGON;
				end
			end
			pmc_pkg::PMC_S_REGON: begin
				if (settle_q == 16'h0000) begin
					st_d = pmc_pkg::PMC_S_UNGATE;
				end
			end
			pmc_pkg::PMC_S_UNGATE: begin
				st_d = pmc_pkg::PMC_S_RUN;
			end
			default: begin
				st_d = pmc_pkg::PMC_S_RUN;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// sequencer and settle counter
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q     <= pmc_pkg::PMC_S_RUN;
			settle_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			if (st_q == pmc_pkg::PMC_S_LOW) begin
				settle_q <= in_hib ? 16'(HIB_SETTLE) : 16'(SLEEP_SETTLE);
			end else if (settle_q != 16'h0000) begin
				settle_q <= settle_q - 16'h0001;
			end
		end
	end

	// ---------------------------------------------------------------
	// wake pending flag
	// ---------------------------------------------------------------
	// event wins over the clear so none is lost at the exit edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_pend_q <= 1'b0;
		end else if (wake_ev && st_q != pmc_pkg::PMC_S_RUN) begin
			wake_pend_q <= 1'b1;
		end else if (st_q == pmc_pkg::PMC_S_UNGATE || st_q == pmc_pkg::PMC_S_RUN) begin
			wake_pend_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// global mode register
	// ---------------------------------------------------------------
	// writes are refused while a low power cycle is in flight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= pmc_pkg::PMC_ACTIVE;
		end else if (st_q == pmc_pkg::PMC_S_UNGATE) begin
			mode_q <= pmc_pkg::PMC_ACTIVE;
		end else if (st_q == pmc_pkg::PMC_S_RUN && wake_ev) begin
			mode_q <= pmc_pkg::PMC_ACTIVE;
		end else if (md_wr && st_q == pmc_pkg::PMC_S_RUN) begin
			mode_q <= pmc_pkg::pmc_mode_t'(pwdata[1:0]);
		end
	end

	// ---------------------------------------------------------------
	// templates and wake enables, kept through hibernate
	// ---------------------------------------------------------------
	// wake sets the processor bit and beats a same-cycle clear
	wire cpu_wake = wake_ev || st_q == pmc_pkg::PMC_S_UNGATE;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_tmpl_q <= `PMC_RST_TMPL;
			alt_tmpl_q <= `PMC_RST_ALT_TMPL;
			wake_en_q  <= `PMC_RST_WAKE_EN;
		end else begin
			if (wr && hit_act) begin
				act_tmpl_q <= pwdata[`PMC_RES_W-1:0];
			end
			if (cpu_wake) begin
				act_tmpl_q[`PMC_RES_CPU] <= 1'b1;
			end
			if (wr && hit_alt) begin
				alt_tmpl_q <= pwdata[`PMC_RES_W-1:0];
			end
			if (wr && hit_wen) begin
				wake_en_q <= pwdata[7:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// periodic timewheel
	// ---------------------------------------------------------------
	// stops in hibernate since the low speed clock is off there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tw_q <= `PMC_RST_TW;
		end else if (wr && hit_tw && pwdata[`PMC_TW_CLR]) begin
			tw_q <= `PMC_RST_TW;
		end else if (lso_tick_1k && !in_hib) begin
			tw_q <= tw_q + 13'h0001;
		end
	end

	// ---------------------------------------------------------------
	// resource enables
	// ---------------------------------------------------------------
	wire [`PMC_RES_W-1:0] rtc_only = `PMC_RES_W'(1) << `PMC_RES_RTC;
	wire run_on = st_q == pmc_pkg::PMC_S_RUN && st_d == pmc_pkg::PMC_S_RUN;
	wire [`PMC_RES_W-1:0] tmpl_sel = mode_q == pmc_pkg::PMC_ALT ? alt_tmpl_q : act_tmpl_q;
	wire [`PMC_RES_W-1:0] res_d = run_on ? tmpl_sel
		: (mode_q == pmc_pkg::PMC_SLEEP ? rtc_only : '0);
	wire clk_on_d = st_d == pmc_pkg::PMC_S_RUN || st_d == pmc_pkg::PMC_S_UNGATE;
	wire reg_on_d = st_d != pmc_pkg::PMC_S_REGOFF && st_d != pmc_pkg::PMC_S_LOW;

	// clocks and bias follow the same per-resource enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_clk_en  <= `PMC_RST_TMPL;
			res_bias_en <= `PMC_RST_TMPL;
			bus_clk_en  <= 1'b1;
			reg_en      <= 1'b1;
			pin_hold    <= 1'b0;
		end else begin
			res_clk_en  <= res_d;
			res_bias_en <= res_d;
			bus_clk_en  <= clk_on_d;
			reg_en      <= reg_on_d;
			pin_hold    <= in_hib && st_d != pmc_pkg::PMC_S_RUN;
		end
	end

	// ---------------------------------------------------------------
	// boost converter control
	// ---------------------------------------------------------------
	// clock sources are plain levels here, muxed without glitch filter
	wire xtal_edge = xtal_32k ^ xtal_q;
	wire hib_low   = in_hib && st_q == pmc_pkg::PMC_S_LOW;
	wire sw_clk_d  = boost_q.freq == `PMC_FREQ_32K ? xtal_32k
		: boost_osc[boost_q.freq];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boost_q      <= '0;
			xtal_q       <= 1'b0;
			boost_en     <= 1'b0;
			boost_active <= 1'b0;
			boost_sw_clk <= 1'b0;
			boost_pulse  <= 1'b0;
		end else begin
			if (wr && hit_bst) begin
				boost_q <= pmc_pkg::pmc_boost_t'(pwdata[4:0]);
			end
			xtal_q       <= xtal_32k;
			boost_en     <= boost_q.en;
			boost_active <= boost_q.active | hib_low;
			boost_sw_clk <= boost_q.en & sw_clk_d;
			boost_pulse  <= boost_q.en & boost_q.auto_pulse & xtal_edge & boost_below;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// cycles since wake was flagged, for the latency bound
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lat_q <= 16'h0000;
		end else if (wake_pend_q && st_q != pmc_pkg::PMC_S_RUN) begin
			lat_q <= lat_q + 16'h0001;
		end else begin
			lat_q <= 16'h0000;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sleep_wake_time_a: assert property (
		mode_q == pmc_pkg::PMC_SLEEP |-> lat_q < 16'(SLEEP_CYC))
		else $error("sleep wake too slow");
	hib_wake_time_a: assert property (
		in_hib |-> lat_q < 16'(HIB_WAKE_CYC))
		else $error("hibernate wake too slow");
	gate_before_reg_a: assert property (
		$fell(reg_en) |-> !bus_clk_en && $past(!bus_clk_en))
		else $error("regulator off before clocks gated");
	reg_before_ungate_a: assert property (
		$rose(bus_clk_en) |-> reg_en && $past(reg_en, 2))
		else $error("clocks on before regulator settled");
	hib_pin_only_a: assert property (
		hib_low && !wake_pend_q && !pin_ev |=> st_q == pmc_pkg::PMC_S_LOW)
		else $error("hibernate left without pin wake");
	wake_forces_active_a: assert property (
		st_q == pmc_pkg::PMC_S_RUN && wake_ev
		|=> mode_q == pmc_pkg::PMC_ACTIVE && act_tmpl_q[`PMC_RES_CPU])
		else $error("wake did not restore active");
	tmpl_follow_a: assert property (
		run_on ##1 run_on && mode_q == pmc_pkg::PMC_ACTIVE
		|=> res_clk_en == $past(act_tmpl_q) && res_bias_en == res_clk_en)
		else $error("resource enable ignores template");
	sleep_res_off_a: assert property (
		mode_q == pmc_pkg::PMC_SLEEP && st_q == pmc_pkg::PMC_S_LOW
		|-> res_clk_en == rtc_only)
		else $error("resource left on in sleep");
	hib_boost_hold_a: assert property (
		hib_low |=> boost_active && pin_hold)
		else $error("boost or pins not held in hibernate");
	auto_pulse_a: assert property (
		boost_q.en && boost_q.auto_pulse && boost_below && xtal_edge |=> boost_pulse)
		else $error("auto pulse missed crystal edge");

endmodule // pmc_power_ctrl

`default_nettype wire

// ---- tb/pmc_power_ctrl_tb.sv ----
// self-checking testbench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"

module pmc_power_ctrl_tb;
	localparam int HIB = 40;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, res_clk_en, res_bias_en;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  wake_irq;
	logic [2:0]  wake_rst, boost_osc;
	logic        lso_tick_1k, xtal_32k, boost_below, bus_clk_en, reg_en, pin_hold;
	logic        boost_en, boost_active, boost_sw_clk, boost_pulse;
	logic [6:0]  src;
	int          error_cnt, n_tests, cyc, i, f;

	pmc_power_ctrl #(.HIB_WAKE_CYC(HIB)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wake_irq(wake_irq), .wake_rst(wake_rst),
		.lso_tick_1k(lso_tick_1k), .xtal_32k(xtal_32k), .boost_below(boost_below),
		.boost_osc(boost_osc), .res_clk_en(res_clk_en), .res_bias_en(res_bias_en),
		.bus_clk_en(bus_clk_en), .reg_en(reg_en), .pin_hold(pin_hold),
		.boost_en(boost_en), .boost_active(boost_active),
		.boost_sw_clk(boost_sw_clk), .boost_pulse(boost_pulse));

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; holds the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one-cycle wake request, low nibble interrupts, top three resets
	task automatic pulse(input logic [6:0] s);
		@(posedge pclk);
		wake_irq <= s[3:0];
		wake_rst <= s[6:4];
		@(posedge pclk);
		wake_irq <= 4'h0;
		wake_rst <= 3'h0;
	endtask

	task automatic enter(input logic [1:0] m, input logic [7:0] e);
		apb(1'b1, `PMC_OFF_MODE, 32'(m));
		// boost hold follows the low state by one edge, two edges after the regulators drop
		tick(5);
		chk(32'(bus_clk_en), 32'h0);
		chk(32'(reg_en), 32'h0);
		chk(32'(res_clk_en), 32'(e));
	endtask

	// regulators must already be up when the bus clock returns
	task automatic wake_time(input int lim);
		cyc = 0;
		while (bus_clk_en !== 1'b1 && cyc < lim) begin
			@(posedge pclk);
			cyc++;
		end
		chk(32'(cyc < lim), 32'h1);
		chk(32'(reg_en), 32'h1);
		tick(4);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog: the whole sequence needs about 41000 cycles
	initial begin
		repeat (60000) @(posedge pclk);
		error_cnt++;
		end_of_test();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
		pwdata = 0; wake_irq = 0; wake_rst = 0; lso_tick_1k = 0; xtal_32k = 0;
		boost_below = 0; boost_osc = 0; error_cnt = 0; n_tests = 0;
		tick(6);
		presetn <= 1'b1;
		chk(32'(res_clk_en), 32'hFF);
		rdc(`PMC_OFF_MODE, 32'h0);
		rdc(`PMC_OFF_ACT_TMPL, 32'hFF);
		rdc(`PMC_OFF_ALT_TMPL, 32'hFE);
		rdc(`PMC_OFF_WAKE_EN, 32'hFF);
		rdc(`PMC_OFF_BOOST, 32'h0);
		rdc(`PMC_OFF_STATUS, 32'h0);
		rdc(8'h1C, 32'h0);
		chk(32'(err), 32'h1);
		$display("test reset done");

		// templates, processor self-off and alternate mode
		apb(1'b1, `PMC_OFF_ACT_TMPL, 32'h5A);
		tick(2);
		chk(32'(res_clk_en), 32'h5A);
		chk(32'(res_bias_en), 32'h5A);
		pulse(7'h02);
		tick(2);
		chk(32'(res_clk_en), 32'h5B);
		apb(1'b1, `PMC_OFF_ALT_TMPL, 32'h3C);
		apb(1'b1, `PMC_OFF_MODE, 32'h1);
		tick(2);
		chk(32'(res_clk_en), 32'h3C);
		rdc(`PMC_OFF_STATUS, 32'h1);
		pulse(7'h01);
		tick(2);
		rdc(`PMC_OFF_MODE, 32'h0);
		chk(32'(res_clk_en), 32'h5B);
		apb(1'b1, `PMC_OFF_ACT_TMPL, 32'hFF);
		$display("test templates done");

		// sleep: each interrupt and reset source alone, the others must not wake
		for (i = 0; i < 7; i++) begin
			src = 7'h1 << i;
			apb(1'b1, `PMC_OFF_WAKE_EN, 32'h1 << (i < 4 ? i : i + 1));
			enter(2'h2, 8'h80);
			pulse(~src);
			tick(20);
			chk(32'(reg_en), 32'h0);
			pulse(src);
			wake_time(3000);
			rdc(`PMC_OFF_STATUS, 32'h0);
		end
		$display("test sleep done");

		// hibernate: only the pin interrupt wakes
		apb(1'b1, `PMC_OFF_WAKE_EN, 32'hFF);
		apb(1'b1, `PMC_OFF_ACT_TMPL, 32'hA5);
		apb(1'b1, `PMC_OFF_BOOST, 32'h1);
		tick(2);
		chk(32'(boost_active), 32'h0);
		enter(2'h3, 8'h00);
		chk(32'(pin_hold), 32'h1);
		chk(32'(boost_active), 32'h1);
		pulse(7'h77);
		tick(20);
		chk(32'(reg_en), 32'h0);
		pulse(7'h08);
		wake_time(HIB);
		chk(32'(pin_hold), 32'h0);
		chk(32'(boost_active), 32'h0);
		rdc(`PMC_OFF_ACT_TMPL, 32'hA5);
		$display("test hibernate done");

		// automatic pulses on both crystal edges while below level
		apb(1'b1, `PMC_OFF_BOOST, 32'h1F);
		boost_below <= 1'b1;
		for (i = 0; i < 4; i++) begin
			if (i == 2)
				boost_below <= 1'b0;
			@(posedge pclk);
			xtal_32k <= ~xtal_32k;
			cyc = 0;
			repeat (4) begin
				@(posedge pclk);
				cyc += (boost_pulse === 1'b1);
			end
			chk(cyc, i < 2 ? 1 : 0);
		end
		chk(32'(boost_en), 32'h1);
		chk(32'(boost_active), 32'h1);

		// switching clock follows the selected source
		for (f = 0; f < 4; f++) begin
			apb(1'b1, `PMC_OFF_BOOST, 32'h1 | (f << 2));
			boost_osc <= f < 3 ? 3'h1 << f : 3'h0;
			xtal_32k <= (f == 3);
			tick(3);
			chk(32'(boost_sw_clk), 32'h1);
			boost_osc <= f < 3 ? ~(3'h1 << f) : 3'h7;
			xtal_32k <= (f != 3);
			tick(3);
			chk(32'(boost_sw_clk), 32'h0);
		end
		$display("test boost done");

		// timewheel counts ticks and clears on request
		apb(1'b1, `PMC_OFF_TW_CTRL, 32'h1);
		repeat (5) begin
			@(posedge pclk);
			lso_tick_1k <= 1'b1;
			@(posedge pclk);
			lso_tick_1k <= 1'b0;
		end
		rdc(`PMC_OFF_STATUS, 32'h5 << 16);
		apb(1'b1, `PMC_OFF_TW_CTRL, 32'h1);
		rdc(`PMC_OFF_STATUS, 32'h0);

		// timewheel wrap is the only enabled source and wakes from sleep
		apb(1'b1, `PMC_OFF_WAKE_EN, 32'h10);
		enter(2'h2, 8'h80);
		repeat (8192) begin
			@(posedge pclk);
			lso_tick_1k <= 1'b1;
			@(posedge pclk);
			lso_tick_1k <= 1'b0;
		end
		wake_time(3000);
		rdc(`PMC_OFF_STATUS, 32'h0);
		$display("test timewheel done");
		end_of_test();
	end
endmodule // pmc_power_ctrl_tb

`default_nettype wire
